// ### ric_pkg.sv
// Constants and carrier types for the reset and interrupt front end.
// Assumes one system clock; the two output phases are derived from it.
package ric_pkg;
    // ****************************************************
    // Widths and positions
    // ****************************************************
    localparam int REG_W = 32;
    localparam int ADDR_W = 24;
    localparam int GIE_BIT = 13;
    localparam int DMA_IE_SHIFT = 16;
    localparam int N_BUS = 4;
    localparam int N_MISC = 16;
    localparam int VEC_W = 5;
    // ****************************************************
    // Reset values and timing
    // ****************************************************
    localparam logic [REG_W-1:0] REG_RST = 32'h00000000;
    localparam logic [ADDR_W-1:0] RESET_VEC_ADDR = 24'h000000;
    localparam logic [VEC_W-1:0] EXT_VEC_BASE = 5'h01;
    localparam logic PH_INIT = 1'b0;
    localparam int CLK_MHZ = 40;
    localparam int CLK_PER_PHASE_CYC = 2;
    localparam int RESET_MIN_PHASE_CYC = 10;
    localparam int RESET_MIN_CLK = RESET_MIN_PHASE_CYC * CLK_PER_PHASE_CYC;
    localparam logic [1:0] ACK_LEN = 2'(CLK_PER_PHASE_CYC);
    // ****************************************************
    // Carriers
    // ****************************************************
    typedef struct packed {
        logic prim_rw;
        logic primary_strobe;
        logic expansion_read_write;
        logic expansion_mem_strobe;
        logic expansion_io_strobe;
    } ric_strobe_t;
    localparam ric_strobe_t STROBE_IDLE = 5'h1F;
    typedef struct packed {
        logic [N_BUS-1:0] bus_oe_n;
        ric_strobe_t strobe;
        logic [N_MISC-1:0] misc_oe_n;
    } ric_pins_t;
    typedef struct packed {
        logic cond_we;
        logic ie_we;
        logic flag_we;
        logic iof_we;
        logic [REG_W-1:0] data;
    } ric_sw_wr_t;
    typedef enum logic [1:0] {BOOT_HOLD, BOOT_FETCH, BOOT_RUN} ric_boot_t;
endpackage

// ### ric_reset_irq.sv
// Reset sequencing, pin reset states and interrupt flag logic.
// Assumes core logic on clk_sys_in supplies normal pin values and takes.
`timescale 1ns/100ps
module ric_reset_irq
    import ric_pkg::*;
#(
    parameter int N_EXT = 4,
    parameter int N_INT = 8
)(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ext_reset_n_in,
    input wire logic [N_EXT-1:0] ext_irq_line_in,
    input wire logic [N_INT-1:0] int_irq_pulse_in,
    input wire ric_sw_wr_t sw_wr_in,
    input wire logic cpu_take_in,
    input wire logic [N_EXT+N_INT-1:0] dma_ack_in,
    input wire logic dma_ctrl_en_in,
    input wire logic [1:0] dma_sync_mode_bits_in,
    input wire logic irq_ack_output_exec_in,
    input wire logic [ADDR_W-1:0] irq_ack_output_operand_in,
    input wire logic [REG_W-1:0] vec_data_in,
    input wire logic vec_valid_in,
    input wire ric_pins_t core_pins_in,
    output logic clock_phase_one_out,
    output logic clock_phase_three_out,
    output ric_pins_t pins_out,
    output logic periph_rst_n_out,
    output logic [REG_W-1:0] cpu_condition_reg_out,
    output logic [REG_W-1:0] interrupt_enable_reg_out,
    output logic [REG_W-1:0] irq_flag_reg_out,
    output logic [REG_W-1:0] io_flag_reg_out,
    output logic cpu_irq_req_out,
    output logic [VEC_W-1:0] cpu_vector_out,
    output logic dma_irq_req_out,
    output logic irq_ack_output_n_out,
    output logic dummy_read_out,
    output logic [ADDR_W-1:0] dummy_read_addr_out,
    output logic vec_fetch_out,
    output logic [ADDR_W-1:0] vec_fetch_addr_out,
    output logic [ADDR_W-1:0] program_counter_out
);
    localparam int NSRC = N_EXT + N_INT;
    localparam logic [REG_W-1:0] SRC_MASK = REG_W'((64'h1 << NSRC) - 64'h1);

    typedef struct packed {
        logic r1;
        logic r2;
        logic [N_EXT-1:0] s1;
        logic [N_EXT-1:0] s2;
        logic [N_EXT-1:0] s3;
        logic rst_act;
        logic ph;
        logic h1;
        logic h3;
        logic [REG_W-1:0] cond;
        logic [REG_W-1:0] ie;
        logic [REG_W-1:0] flags;
        logic [REG_W-1:0] io_flag_reg;
        logic irq_req;
        logic dma_req;
        logic [VEC_W-1:0] vec;
        logic [1:0] ack_cnt;
        logic ack_n;
        logic rd_req;
        logic [ADDR_W-1:0] rd_addr;
        ric_boot_t boot;
        logic vec_fetch;
        logic [ADDR_W-1:0] pc;
        logic periph_rst_n;
        ric_pins_t pins;
    } ric_state_t;

    ric_state_t st;
    ric_state_t next_st;

    // ****************************************************
    // Lowest pending index
    // ****************************************************
    function automatic logic [VEC_W-1:0] ric_lowest(input logic [REG_W-1:0] v);
        logic [VEC_W-1:0] r;
        r = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = VEC_W'(i);
            end
        end
        return r;
    endfunction

    logic [REG_W-1:0] pend_cpu;
    logic [REG_W-1:0] pend_dma;
    logic [REG_W-1:0] hw_set;
    logic [REG_W-1:0] take_clr;
    logic [REG_W-1:0] flag_base;
    logic [VEC_W-1:0] top_idx;
    logic rst_fall;
    logic dma_gie;

    assign pend_cpu = st.flags & st.ie & SRC_MASK;
    assign pend_dma = st.flags & (st.ie >> DMA_IE_SHIFT) & SRC_MASK;
    assign top_idx = ric_lowest(pend_cpu);
    assign rst_fall = !st.r2 && !st.rst_act;
    assign dma_gie = dma_ctrl_en_in && (dma_sync_mode_bits_in != 2'h0);

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb
    begin
        next_st = st;
        // Reset pin synchroniser
        next_st.r1 = ext_reset_n_in;
        next_st.r2 = st.r1;
        next_st.rst_act = !st.r2;
        // Interrupt lines: two flops, third on the second half cycle
        next_st.s1 = ext_irq_line_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.ph ? st.s2 : st.s3;
        // Phase generator, pinned on reset fall
        next_st.ph = rst_fall ? PH_INIT : !st.ph;
        next_st.h1 = !next_st.ph;
        next_st.h3 = next_st.ph;
        // Flag, serial and timer pins float at once
        next_st.pins.misc_oe_n = next_st.rst_act ? '1 : core_pins_in.misc_oe_n;

        // Flag register
        hw_set = REG_W'({int_irq_pulse_in, ~st.s3});
        take_clr = (cpu_take_in && st.irq_req) ? REG_W'(64'h1 << top_idx) : '0;
        flag_base = (sw_wr_in.flag_we && !st.rst_act) ? sw_wr_in.data : st.flags;
        flag_base = (flag_base | hw_set) & SRC_MASK;
        next_st.flags = flag_base & ~(take_clr | (REG_W'(dma_ack_in)));

        if (!st.rst_act)
        begin
            next_st.cond = sw_wr_in.cond_we ? sw_wr_in.data : st.cond;
            next_st.ie = sw_wr_in.ie_we ? sw_wr_in.data : st.ie;
            next_st.io_flag_reg = sw_wr_in.iof_we ? sw_wr_in.data : st.io_flag_reg;
            next_st.pins.bus_oe_n = core_pins_in.bus_oe_n;
            next_st.pins.strobe = core_pins_in.strobe;
            next_st.periph_rst_n = 1'b1;
        end
        if (cpu_take_in && st.irq_req)
        begin
            next_st.cond[GIE_BIT] = 1'b0;
        end

        // Requests and vector
        next_st.irq_req = st.cond[GIE_BIT] && (pend_cpu != '0);
        next_st.dma_req = dma_gie && (pend_dma != '0);
        next_st.vec = VEC_W'(top_idx + EXT_VEC_BASE);

        // Acknowledge instruction
        next_st.rd_req = 1'b0;
        if (st.ack_cnt != 2'h0)
        begin
            next_st.ack_cnt = st.ack_cnt - 2'h1;
        end
        else if (irq_ack_output_exec_in && st.boot == BOOT_RUN)
        begin
            next_st.ack_cnt = ACK_LEN;
            next_st.rd_req = 1'b1;
            next_st.rd_addr = irq_ack_output_operand_in;
        end
        next_st.ack_n = (next_st.ack_cnt == 2'h0);

        // Reset vector fetch
        case (st.boot)
            BOOT_HOLD:
            begin
                if (!st.rst_act)
                begin
                    next_st.boot = BOOT_FETCH;
                    next_st.vec_fetch = 1'b1;
                end
            end
            BOOT_FETCH:
            begin
                if (vec_valid_in)
                begin
                    next_st.pc = vec_data_in[ADDR_W-1:0];
                    next_st.vec_fetch = 1'b0;
                    next_st.boot = BOOT_RUN;
                end
            end
            BOOT_RUN:
            begin
                next_st.vec_fetch = 1'b0;
            end
            default:
            begin
                next_st.boot = BOOT_HOLD;
                next_st.vec_fetch = 1'b0;
            end
        endcase

        // Phase-timed reset actions
        if (st.rst_act && st.ph)
        begin
            next_st.pins.bus_oe_n = '1;
            next_st.pins.strobe = STROBE_IDLE;
            next_st.ack_cnt = 2'h0;
            next_st.ack_n = 1'b1;
            next_st.rd_req = 1'b0;
            next_st.periph_rst_n = 1'b0;
            next_st.cond = REG_RST;
            next_st.ie = REG_RST;
            next_st.flags = REG_RST;
            next_st.io_flag_reg = REG_RST;
            next_st.irq_req = 1'b0;
            next_st.dma_req = 1'b0;
            next_st.boot = BOOT_HOLD;
            next_st.vec_fetch = 1'b0;
        end
    end

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0;
            st.r1 <= 1'b0;
            st.r2 <= 1'b0;
            st.s1 <= '1;
            st.s2 <= '1;
            st.s3 <= '1;
            st.rst_act <= 1'b1;
            st.h1 <= 1'b1;
            st.ack_n <= 1'b1;
            st.pins <= '1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign clock_phase_one_out = st.h1;
    assign clock_phase_three_out = st.h3;
    assign pins_out = st.pins;
    assign periph_rst_n_out = st.periph_rst_n;
    assign cpu_condition_reg_out = st.cond;
    assign interrupt_enable_reg_out = st.ie;
    assign irq_flag_reg_out = st.flags;
    assign io_flag_reg_out = st.io_flag_reg;
    assign cpu_irq_req_out = st.irq_req;
    assign cpu_vector_out = st.vec;
    assign dma_irq_req_out = st.dma_req;
    assign irq_ack_output_n_out = st.ack_n;
    assign dummy_read_out = st.rd_req;
    assign dummy_read_addr_out = st.rd_addr;
    assign vec_fetch_out = st.vec_fetch;
    assign vec_fetch_addr_out = RESET_VEC_ADDR;
    assign program_counter_out = st.pc;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    property p_bus_hiz;
        st.rst_act && st.ph |=> st.pins.bus_oe_n == '1 && st.periph_rst_n == 1'b0;
    endproperty
    a_bus_hiz: assert property (p_bus_hiz) else $error("bus not floated");
    property p_strobe_idle;
        st.rst_act && st.ph |=> st.pins.strobe == STROBE_IDLE && irq_ack_output_n_out;
    endproperty
    a_strobe_idle: assert property (p_strobe_idle) else $error("strobe active");
    property p_misc_float;
        st.r2 == 1'b0 |=> st.pins.misc_oe_n == '1;
    endproperty
    a_misc_float: assert property (p_misc_float) else $error("misc not floated");
    property p_phase_fix;
        rst_fall |=> st.ph == PH_INIT && st.h1 && !st.h3 ##1 !st.h1;
    endproperty
    a_phase_fix: assert property (p_phase_fix) else $error("phase not fixed");
    property p_regs_zero;
        st.rst_act && st.ph |=> st.cond == '0 && st.ie == '0 && st.flags == '0 && st.io_flag_reg == '0;
    endproperty
    a_regs_zero: assert property (p_regs_zero) else $error("regs not cleared");
    property p_set_wins;
        !st.rst_act && int_irq_pulse_in[0] && sw_wr_in.flag_we && !sw_wr_in.data[N_EXT]
            && !dma_ack_in[N_EXT] && !cpu_take_in |=> st.flags[N_EXT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag set lost");
    property p_gie_gate;
        !st.cond[GIE_BIT] |=> !cpu_irq_req_out;
    endproperty
    a_gie_gate: assert property (p_gie_gate) else $error("request without enable");
    property p_take_clr;
        cpu_take_in && st.irq_req && !st.rst_act |=> !st.cond[GIE_BIT];
    endproperty
    a_take_clr: assert property (p_take_clr) else $error("enable not cleared");
    property p_irq_ack_output;
        irq_ack_output_exec_in && st.ack_cnt == 2'h0 && st.boot == BOOT_RUN && !(st.rst_act && st.ph)
            |=> dummy_read_out && !irq_ack_output_n_out ##1 !irq_ack_output_n_out ##1
            irq_ack_output_n_out;
    endproperty
    a_irq_ack_output: assert property (p_irq_ack_output) else $error("ack pulse wrong");
    property p_vec_load;
        st.boot == BOOT_FETCH && vec_valid_in && !(st.rst_act && st.ph)
            |=> program_counter_out == $past(vec_data_in[ADDR_W-1:0]);
    endproperty
    a_vec_load: assert property (p_vec_load) else $error("vector not loaded");
    c_reset_boot: cover property (st.boot == BOOT_FETCH ##[1:20] st.boot == BOOT_RUN);
    c_irq_taken: cover property (cpu_irq_req_out && cpu_take_in);
    c_reflag: cover property (dma_ack_in[0] && !st.s3[0] ##1 st.flags[0]);
endmodule

// ### ric_board_model.sv
// Board-side model that drives the device reset pin and the interrupt lines.
// Assumes the bench calls its tasks from a process clocked by clk_sys_in.
`timescale 1ns/100ps
module ric_board_model
    import ric_pkg::*;
#(
    parameter int N_EXT = 4
)(
    input wire logic clk_sys_in,
    output logic ext_reset_n_out,
    output logic [N_EXT-1:0] ext_irq_line_out
);
    // Lines are pulled up, so idle is high
    initial
    begin
        ext_reset_n_out = 1'b1;
        ext_irq_line_out = '1;
    end

    task automatic pulse_reset(input int n);
        int k;
        k = (n < RESET_MIN_CLK) ? RESET_MIN_CLK : n;
        @(posedge clk_sys_in);
        ext_reset_n_out <= 1'b0;
        repeat (k) @(posedge clk_sys_in);
        ext_reset_n_out <= 1'b1;
    endtask

    task automatic pulse_irq(input int idx, input int n);
        int k;
        k = (n < CLK_PER_PHASE_CYC) ? CLK_PER_PHASE_CYC : n;
        @(posedge clk_sys_in);
        ext_irq_line_out[idx] <= 1'b0;
        repeat (k) @(posedge clk_sys_in);
        ext_irq_line_out[idx] <= 1'b1;
    endtask
endmodule

// ### test_reset_interrupt_control.sv
// Self-checking bench for the reset and interrupt front end.
// Assumes ric_pkg, the design and the board model are compiled first.
`timescale 1ns/100ps
module test_reset_interrupt_control
    import ric_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ext_rst_n;
    logic [3:0] ext_irq;
    logic [7:0] int_irq = '0;
    ric_sw_wr_t sw_wr = '0;
    logic take = 1'b0;
    logic [11:0] dma_ack = '0;
    logic dma_en = 1'b0;
    logic [1:0] dma_sync = '0;
    logic irq_ack_output = 1'b0;
    logic [ADDR_W-1:0] irq_ack_output_op = '0;
    logic [REG_W-1:0] vec_data = '0;
    logic vec_valid = 1'b0;
    ric_pins_t core_pins = '0;
    logic ph1, ph3, prst_n, cpu_irq, dma_irq, ack_n, dread, vfetch;
    ric_pins_t pins;
    logic [REG_W-1:0] cond_r, ie_r, flag_r, iof_r, f;
    logic [VEC_W-1:0] vec;
    logic [ADDR_W-1:0] dr_addr, vf_addr, pc;
    int fails = 0;
    int n_checks = 0;
    int seed = 54;
    int k;

    always #12.5 clk_sys_in = ~clk_sys_in;

    ric_board_model board_u (.clk_sys_in(clk_sys_in), .ext_reset_n_out(ext_rst_n),
        .ext_irq_line_out(ext_irq));

    ric_reset_irq dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .ext_reset_n_in(ext_rst_n), .ext_irq_line_in(ext_irq), .int_irq_pulse_in(int_irq),
        .sw_wr_in(sw_wr), .cpu_take_in(take), .dma_ack_in(dma_ack), .dma_ctrl_en_in(dma_en),
        .dma_sync_mode_bits_in(dma_sync), .irq_ack_output_exec_in(irq_ack_output), .irq_ack_output_operand_in(irq_ack_output_op),
        .vec_data_in(vec_data), .vec_valid_in(vec_valid), .core_pins_in(core_pins),
        .clock_phase_one_out(ph1), .clock_phase_three_out(ph3), .pins_out(pins),
        .periph_rst_n_out(prst_n), .cpu_condition_reg_out(cond_r),
        .interrupt_enable_reg_out(ie_r), .irq_flag_reg_out(flag_r), .io_flag_reg_out(iof_r),
        .cpu_irq_req_out(cpu_irq), .cpu_vector_out(vec), .dma_irq_req_out(dma_irq),
        .irq_ack_output_n_out(ack_n), .dummy_read_out(dread), .dummy_read_addr_out(dr_addr),
        .vec_fetch_out(vfetch), .vec_fetch_addr_out(vf_addr), .program_counter_out(pc));

    // ****************************************************
    // Checking and bus tasks
    // ****************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [VEC_W-1:0] exp_vec(input logic [31:0] fl, input logic [31:0] en);
        for (int i = 0; i < 12; i++)
            if (fl[i] && en[i])
                return VEC_W'(i) + EXT_VEC_BASE;
        return '0;
    endfunction

    task automatic wr(input int sel, input logic [31:0] dt);
        @(posedge clk_sys_in);
        sw_wr <= '{cond_we:(sel == 0), ie_we:(sel == 1), flag_we:(sel == 2),
                   iof_we:(sel == 3), data:dt};
        @(posedge clk_sys_in);
        sw_wr <= '0;
        @(negedge clk_sys_in);
    endtask

    task automatic take_irq();
        @(posedge clk_sys_in);
        take <= 1'b1;
        @(posedge clk_sys_in);
        take <= 1'b0;
        @(negedge clk_sys_in);
    endtask

    task automatic fetch();
        logic [31:0] dv;
        int n;
        dv = $random(seed);
        n = 0;
        while (vfetch !== 1'b1 && n < 20)
        begin
            @(negedge clk_sys_in);
            n++;
        end
        chk(vfetch, 1);
        chk(vf_addr, RESET_VEC_ADDR);
        @(posedge clk_sys_in);
        vec_data <= dv;
        vec_valid <= 1'b1;
        @(posedge clk_sys_in);
        vec_valid <= 1'b0;
        @(negedge clk_sys_in);
        chk(pc, dv[ADDR_W-1:0]);
        chk(vfetch, 0);
    endtask

    task automatic finish_test();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_sys_in);
        fails++;
        finish_test();
    end

    // ****************************************************
    // Scenarios
    // ****************************************************
    initial
    begin
        repeat (11) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk(pins.bus_oe_n, 4'hF);
        chk(pins.strobe, STROBE_IDLE);
        chk(pins.misc_oe_n, 16'hFFFF);
        chk(ack_n, 1);
        chk(flag_r | cond_r | ie_r | iof_r, 0);
        @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        fetch();
        $display("test power-on reset done");
        for (int s = 0; s < 4; s++)
        begin
            f = $random(seed);
            wr(s, f);
            chk(s == 0 ? cond_r : s == 1 ? ie_r : s == 2 ? flag_r : iof_r,
                s == 2 ? f & 32'hFFF : f);
            wr(s, 0);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(1, 32'h1 << i);
            wr(0, i[0] ? 32'h0 : (32'h1 << GIE_BIT));
            board_u.pulse_irq(i, 4);
            k = 0;
            while (flag_r[i] !== 1'b1 && k < 30)
            begin
                @(negedge clk_sys_in);
                k++;
            end
            chk(flag_r, 32'h1 << i);
            @(negedge clk_sys_in);
            chk(cpu_irq, !i[0]);
            if (!i[0])
            begin
                chk(vec, VEC_W'(i) + EXT_VEC_BASE);
                take_irq();
                chk(cond_r[GIE_BIT], 0);
                repeat (8) @(negedge clk_sys_in);
                chk(flag_r, 0);
            end
            else
            begin
                // Let the synchronised line go high before the clear
                repeat (4) @(negedge clk_sys_in);
                wr(2, 0);
                chk(flag_r, 0);
            end
        end
        $display("test external lines done");
        wr(1, 32'hFFF);
        for (int j = 0; j < 4; j++)
        begin
            f = ($random(seed) & 32'hFFF) | 32'h800;
            wr(0, 32'h1 << GIE_BIT);
            wr(2, f);
            @(negedge clk_sys_in);
            chk(vec, exp_vec(f, 32'hFFF));
            take_irq();
            chk(flag_r, f & ~(32'h1 << (exp_vec(f, 32'hFFF) - EXT_VEC_BASE)));
            wr(2, 0);
        end
        wr(1, 0);
        $display("test priority done");
        for (int j = 0; j < 3; j++)
        begin
            k = $random(seed) & 7;
            @(posedge clk_sys_in);
            int_irq <= 8'h1 << k;
            @(posedge clk_sys_in);
            int_irq <= '0;
            @(negedge clk_sys_in);
            chk(flag_r, 32'h10 << k);
            wr(2, 0);
        end
        @(posedge clk_sys_in);
        int_irq <= 8'h01;
        sw_wr <= '{cond_we:1'b0, ie_we:1'b0, flag_we:1'b1, iof_we:1'b0, data:32'h0};
        @(posedge clk_sys_in);
        int_irq <= '0;
        sw_wr <= '0;
        @(negedge clk_sys_in);
        chk(flag_r, 32'h10);
        wr(2, 0);
        $display("test internal requests done");
        wr(1, 32'h1 << (DMA_IE_SHIFT + 2));
        wr(2, 32'h4);
        for (int s = 0; s < 5; s++)
        begin
            @(posedge clk_sys_in);
            dma_en <= (s < 4);
            dma_sync <= s[1:0] | {1'b0, s == 4};
            repeat (3) @(negedge clk_sys_in);
            chk(dma_irq, s != 0 && s < 4);
        end
        @(posedge clk_sys_in);
        dma_ack <= 12'h004;
        @(posedge clk_sys_in);
        dma_ack <= '0;
        @(negedge clk_sys_in);
        chk(flag_r, 0);
        $display("test dma gating done");
        repeat (2)
        begin
            @(posedge clk_sys_in);
            irq_ack_output <= 1'b1;
            irq_ack_output_op <= ADDR_W'($random(seed));
            @(posedge clk_sys_in);
            irq_ack_output <= 1'b0;
            @(negedge clk_sys_in);
            chk({ack_n, dread}, 2'b01);
            chk(dr_addr, irq_ack_output_op);
            @(negedge clk_sys_in);
            chk({ack_n, dread}, 2'b00);
            @(negedge clk_sys_in);
            chk(ack_n, 1);
        end
        $display("test acknowledge done");
        wr(2, 32'h0F0F);
        wr(3, $random(seed));
        fork
            board_u.pulse_reset(RESET_MIN_CLK);
        join_none
        repeat (12) @(negedge clk_sys_in);
        chk(pins.misc_oe_n, 16'hFFFF);
        chk(pins.bus_oe_n, 4'hF);
        chk(pins.strobe, STROBE_IDLE);
        chk(flag_r | iof_r | cond_r | ie_r, 0);
        chk(prst_n, 0);
        chk({ph1, ph3}, 2'b10);
        repeat (12) @(negedge clk_sys_in);
        fetch();
        $display("test pin reset done");
        finish_test();
    end
endmodule
